// ### rtl/sofc_regs.svh
// Offsets, field positions, reset values and timing counts.
`ifndef SOFC_REGS_SVH
`define SOFC_REGS_SVH
// Device register offsets on the serial control port.
`define SOFC_OFS_FRAME_CTRL 7'h19
`define SOFC_OFS_DRIVE 7'h1a
`define SOFC_OFS_RESOLUTION 7'h1b
`define SOFC_OFS_SKEW 7'h1e
`define SOFC_OFS_PAT_LOW 7'h20
`define SOFC_OFS_PAT_MID 7'h21
`define SOFC_OFS_PAT_HIGH 7'h22
`define SOFC_REG_RESET 8'h00
// Field positions.
`define SOFC_BIT_FRAME_SRC 7
`define SOFC_BIT_FRAME_DIV 4
`define SOFC_BIT_FRAME_STRETCH 0
`define SOFC_BIT_HALF_DRIVE 6
`define SOFC_BIT_REMAP_EN 7
`define SOFC_BIT_WIDE_EN 6
// Resolution codes and widths.
`define SOFC_RES_18 3'h0
`define SOFC_RES_16 3'h1
`define SOFC_RES_14 3'h2
`define SOFC_NATIVE_BITS 5'h0e
// Serial control frame: read flag, 7 address bits, 8 data bits.
`define SOFC_FRAME_BITS 5'h10
`define SOFC_ADDR_BITS 5'h08
// Control clock: 160 ns period from a 5 ns system clock.
`define SOFC_SCLK_PERIOD_NS 160
`define SOFC_SYS_PERIOD_NS 5
`define SOFC_SCLK_HALF ((`SOFC_SCLK_PERIOD_NS/`SOFC_SYS_PERIOD_NS)/2)
// Host Avalon byte offsets.
`define SOFC_AV_CMD 4'h0
`define SOFC_AV_SETUP 4'h4
`define SOFC_AV_STATUS 4'h8
`endif

// ### rtl/sofc_pkg.sv
// Types shared by both ends of the output format configuration link.
package sofc_pkg;
   // Decimation mode of the converter data path.
   typedef enum logic [1:0] {
      DECIM_BYPASS,
      DECIM_REAL,
      DECIM_COMPLEX
   } sofc_decim_t;
   // Serial output wire count.
   typedef enum logic [1:0] {
      WIRE_TWO,
      WIRE_ONE,
      WIRE_HALF
   } sofc_wire_t;
   // Host serial engine states.
   typedef enum logic [1:0] {
      HST_IDLE,
      HST_SHIFT,
      HST_GAP
   } sofc_hst_t;
endpackage : sofc_pkg

// ### rtl/sofc_link_if.sv
// Pins between the converter and its controller.
`timescale 1ns/100ps
`default_nettype none
interface sofc_link_if;
   logic sclk;
   logic csN;
   logic sdi;
   logic sdo;
   logic serialData;
   logic bitClock;
   logic frameClock;
   modport dev (input sclk, csN, sdi,
      output sdo, serialData, bitClock, frameClock);
   modport host (output sclk, csN, sdi,
      input sdo, serialData, bitClock, frameClock);
endinterface : sofc_link_if
`default_nettype wire

// ### rtl/sofc_device.sv
// Converter end: serial control port, format registers and serializer.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "sofc_regs.svh"
`default_nettype none
module sofc_device (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Link pins.
   sofc_link_if.dev link,
   // Data path mode and samples from the converter core.
   input wire sofc_pkg::sofc_decim_t decimMode,
   input wire logic [19:0] sampleIn,
   output logic sampleTake,
   input wire logic decimFrame,
   // Analog pad controls.
   output logic halfDrive,
   output logic [1:0] dataLaneSkew,
   output logic [1:0] bitClockSkew,
   output logic [4:0] outBits
);
   //////////////////////////////////////////////////////////////////
   // Register storage.
   logic [7:0] frameCtrl_r;
   logic [7:0] drive_r;
   logic [7:0] resCtrl_r;
   logic [7:0] skew_r;
   logic [7:0] patLow_r;
   logic [7:0] patMid_r;
   logic [7:0] patHigh_r;
   // Synchronisers and stable levels of the control pins.
   logic [2:0] sclkSync_r;
   logic [2:0] csSync_r;
   logic [2:0] sdiSync_r;
   logic sclkLvl_r;
   logic csNLvl_r;
   logic sdiLvl_r;
   // Serial frame state.
   logic [4:0] bitCnt_r;
   logic [14:0] shiftIn_r;
   logic [7:0] shiftOut_r;
   logic sdo_r;
   logic sclkRise;
   logic sclkFall;
   logic [15:0] frameWord;
   // Serializer state.
   logic [19:0] word_r;
   logic [4:0] bitPos_r;
   logic wordSel_r;
   logic serialData_r;
   logic bitClock_r;
   logic frameClock_r;
   logic [19:0] pattern;
   logic coreFrame;
   logic frameNxt;

   //////////////////////////////////////////////////////////////////
   // Register read decode.
   function automatic logic [7:0] regRead(input logic [6:0] a,
      input logic [7:0] fc, dr, rc, sk, pl, pm, ph);
      case (a)
         `SOFC_OFS_FRAME_CTRL: regRead = fc;
         `SOFC_OFS_DRIVE: regRead = dr;
         `SOFC_OFS_RESOLUTION: regRead = rc;
         `SOFC_OFS_SKEW: regRead = sk;
         `SOFC_OFS_PAT_LOW: regRead = pl;
         `SOFC_OFS_PAT_MID: regRead = pm;
         `SOFC_OFS_PAT_HIGH: regRead = ph;
         default: regRead = 8'h00;
      endcase
   endfunction : regRead

   // Output word width from mode and resolution fields.
   function automatic logic [4:0] resBits(input sofc_pkg::sofc_decim_t m,
      input logic [7:0] rc);
      logic [4:0] coded;
      coded = 5'd18;
      case (rc[5:3])
         `SOFC_RES_18: coded = 5'd18;
         `SOFC_RES_16: coded = 5'd16;
         `SOFC_RES_14: coded = 5'd14;
         default: coded = 5'd18;
      endcase
      if (rc[`SOFC_BIT_WIDE_EN]) begin
         resBits = 5'd20;
      end else if (m == sofc_pkg::DECIM_BYPASS) begin
         resBits = rc[`SOFC_BIT_REMAP_EN] ? coded : `SOFC_NATIVE_BITS;
      end else if (m == sofc_pkg::DECIM_COMPLEX &&
         rc[5:3] == `SOFC_RES_18) begin
         resBits = 5'd16;
      end else begin
         resBits = coded;
      end
   endfunction : resBits

   //////////////////////////////////////////////////////////////////
   // Three-stage synchronisers; a level counts once stages 2 and 3 agree.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclkSync_r <= 3'h0;
         csSync_r <= 3'h7;
         sdiSync_r <= 3'h0;
      end else begin
         sclkSync_r <= {sclkSync_r[1:0], link.sclk};
         csSync_r <= {csSync_r[1:0], link.csN};
         sdiSync_r <= {sdiSync_r[1:0], link.sdi};
      end
   end

   // Stable levels taken from the agreeing stages.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclkLvl_r <= 1'b0;
         csNLvl_r <= 1'b1;
         sdiLvl_r <= 1'b0;
      end else begin
         if (sclkSync_r[1] == sclkSync_r[2]) sclkLvl_r <= sclkSync_r[2];
         if (csSync_r[1] == csSync_r[2]) csNLvl_r <= csSync_r[2];
         if (sdiSync_r[1] == sdiSync_r[2]) sdiLvl_r <= sdiSync_r[2];
      end
   end

   // Edges of the control clock while selected.
   assign sclkRise = ~csNLvl_r && ~sclkLvl_r &&
      (sclkSync_r[1] == sclkSync_r[2]) && sclkSync_r[2];
   assign sclkFall = ~csNLvl_r && sclkLvl_r &&
      (sclkSync_r[1] == sclkSync_r[2]) && ~sclkSync_r[2];
   assign frameWord = {shiftIn_r, sdiLvl_r};

   //////////////////////////////////////////////////////////////////
   // Frame receiver: bits taken on rising edges, MSB first.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bitCnt_r <= 5'h00;
         shiftIn_r <= 15'h0000;
      end else if (csNLvl_r) begin
         bitCnt_r <= 5'h00;
      end else if (sclkRise && bitCnt_r != `SOFC_FRAME_BITS) begin
         bitCnt_r <= bitCnt_r + 5'h01;
         shiftIn_r <= frameWord[14:0];
      end
   end

   // Read data: loaded after the address, shifted on falling edges.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shiftOut_r <= 8'h00;
         sdo_r <= 1'b0;
      end else if (sclkRise && bitCnt_r == `SOFC_ADDR_BITS - 5'h01) begin
         {sdo_r, shiftOut_r} <= {regRead(frameWord[6:0], frameCtrl_r,
            drive_r, resCtrl_r, skew_r, patLow_r, patMid_r,
            patHigh_r), 1'b0};
      end else if (sclkFall && bitCnt_r > `SOFC_ADDR_BITS) begin
         {sdo_r, shiftOut_r} <= {shiftOut_r, 1'b0};
      end
   end

   // Register writes on the sixteenth rising edge of a write frame.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         frameCtrl_r <= `SOFC_REG_RESET;
         drive_r <= `SOFC_REG_RESET;
         resCtrl_r <= `SOFC_REG_RESET;
         skew_r <= `SOFC_REG_RESET;
         patLow_r <= `SOFC_REG_RESET;
         patMid_r <= `SOFC_REG_RESET;
         patHigh_r <= `SOFC_REG_RESET;
      end else if (sclkRise && bitCnt_r == `SOFC_FRAME_BITS - 5'h01 &&
         ~frameWord[15]) begin
         case (frameWord[14:8])
            `SOFC_OFS_FRAME_CTRL: frameCtrl_r <= frameWord[7:0];
            `SOFC_OFS_DRIVE: drive_r <= frameWord[7:0];
            `SOFC_OFS_RESOLUTION: resCtrl_r <= frameWord[7:0];
            `SOFC_OFS_SKEW: skew_r <= frameWord[7:0];
            `SOFC_OFS_PAT_LOW: patLow_r <= frameWord[7:0];
            `SOFC_OFS_PAT_MID: patMid_r <= frameWord[7:0];
            `SOFC_OFS_PAT_HIGH: patHigh_r <= frameWord[7:0];
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////
   // Pad controls: drive strength and fixed skew steps.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         halfDrive <= 1'b0;
         dataLaneSkew <= 2'h0;
         bitClockSkew <= 2'h0;
         outBits <= `SOFC_NATIVE_BITS;
      end else begin
         halfDrive <= drive_r[`SOFC_BIT_HALF_DRIVE];
         dataLaneSkew <= skew_r[3:2];
         bitClockSkew <= skew_r[1:0];
         outBits <= resBits(decimMode, resCtrl_r);
      end
   end

   // Frame pattern: upper nibble of the high register is not used.
   assign pattern = {patHigh_r[3:0], patMid_r, patLow_r};
   assign coreFrame = (decimMode == sofc_pkg::DECIM_BYPASS) ?
      (bitPos_r < {1'b0, outBits[4:1]}) :
      pattern[5'd19 - bitPos_r];

   // Frame clock from core or decimation block, divided or stretched.
   always_comb begin
      frameNxt = frameCtrl_r[`SOFC_BIT_FRAME_SRC] ?
         decimFrame : coreFrame;
      if (frameCtrl_r[`SOFC_BIT_FRAME_STRETCH]) begin
         frameNxt = ~wordSel_r;
      end else if (frameCtrl_r[`SOFC_BIT_FRAME_DIV]) begin
         frameNxt = frameNxt & ~wordSel_r;
      end
   end

   // Serializer: one bit per cycle, MSB first, words of outBits bits.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         word_r <= 20'h00000;
         bitPos_r <= 5'h00;
         wordSel_r <= 1'b0;
         serialData_r <= 1'b0;
         bitClock_r <= 1'b0;
         frameClock_r <= 1'b0;
      end else begin
         bitClock_r <= ~bitClock_r;
         serialData_r <= word_r[5'd19 - bitPos_r];
         frameClock_r <= frameNxt;
         if (bitPos_r >= outBits - 5'h01) begin
            bitPos_r <= 5'h00;
            wordSel_r <= ~wordSel_r;
            word_r <= sampleIn;
         end else begin
            bitPos_r <= bitPos_r + 5'h01;
         end
      end
   end

   // Outputs.
   assign sampleTake = (bitPos_r >= outBits - 5'h01);
   assign link.sdo = sdo_r;
   assign link.serialData = serialData_r;
   assign link.bitClock = bitClock_r;
   assign link.frameClock = frameClock_r;
endmodule : sofc_device
`default_nettype wire

// ### rtl/sofc_host.sv
// Controller end: command FIFO, Avalon slave and serial control master.
`timescale 1ns/100ps
`include "sofc_regs.svh"
`default_nettype none
module sofc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Filling side.
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side.
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   // Handshakes with honest full and empty.
   assign inReady = (count_r != DEPTH[AW:0]);
   assign outValid = (count_r != '0);
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outData = mem[rdPtr_r];

   // Storage.
   always_ff @(posedge sys_clk) begin
      if (push) mem[wrPtr_r] <= inData;
   end

   // Pointers and fill count.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) wrPtr_r <= wrPtr_r + 1'b1;
         if (pop) rdPtr_r <= rdPtr_r + 1'b1;
         count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : sofc_fifo

module sofc_host #(
   parameter int SCLK_HALF = `SOFC_SCLK_HALF
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Avalon-MM slave.
   input wire logic [3:0] avAddress,
   input wire logic avRead,
   input wire logic avWrite,
   input wire logic [31:0] avWriteData,
   output logic [31:0] avReadData,
   output logic avWaitRequest,
   // Link pins.
   sofc_link_if.host link
);
   //////////////////////////////////////////////////////////////////
   sofc_pkg::sofc_hst_t state_r;
   logic [15:0] fifoIn;
   logic fifoInValid;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [15:0] fifoOut;
   logic setupPend_r;
   logic [15:0] setupSecond_r;
   logic [15:0] setupFirst;
   logic [15:0] setupRes;
   logic cmdWr;
   logic setupWr;
   logic rdAck_r;
   logic [15:0] shift_r;
   logic [7:0] rdData_r;
   logic [4:0] bits_r;
   logic [7:0] div_r;
   logic sclk_r;
   logic csN_r;
   logic [2:0] sdoSync_r;
   logic sdoLvl_r;
   logic halfTick;
   sofc_pkg::sofc_decim_t sDecim;
   sofc_pkg::sofc_wire_t sWire;

   //////////////////////////////////////////////////////////////////
   // Setup order: frame control word then resolution word.
   assign sDecim = sofc_pkg::sofc_decim_t'(avWriteData[3:2]);
   assign sWire = sofc_pkg::sofc_wire_t'(avWriteData[1:0]);
   always_comb begin
      setupFirst = {1'b0, `SOFC_OFS_FRAME_CTRL, 8'h00};
      setupRes = {1'b0, `SOFC_OFS_RESOLUTION, 2'b00,
         avWriteData[6:4], 3'b000};
      if (sDecim == sofc_pkg::DECIM_COMPLEX) begin
         if (sWire == sofc_pkg::WIRE_HALF) begin
            setupFirst[`SOFC_BIT_FRAME_STRETCH] = 1'b1;
         end else begin
            setupFirst[`SOFC_BIT_FRAME_SRC] = 1'b1;
         end
      end else if (sWire == sofc_pkg::WIRE_TWO) begin
         setupFirst[`SOFC_BIT_FRAME_DIV] = 1'b1;
      end
      // Remap enable only in bypass; decimation leaves it clear.
      setupRes[`SOFC_BIT_REMAP_EN] =
         (sDecim == sofc_pkg::DECIM_BYPASS);
   end

   // Avalon decode; writes wait while the FIFO cannot take them.
   assign cmdWr = avWrite && avAddress == `SOFC_AV_CMD;
   assign setupWr = avWrite && avAddress == `SOFC_AV_SETUP;
   assign fifoInValid = setupPend_r || ((cmdWr || setupWr) && ~setupPend_r);
   assign fifoIn = setupPend_r ? setupSecond_r :
      (setupWr ? setupFirst : avWriteData[15:0]);
   assign avWaitRequest = (avRead && ~rdAck_r) ||
      ((cmdWr || setupWr) && (setupPend_r || ~fifoInReady));

   // Second half of a setup is queued on the following cycles.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         setupPend_r <= 1'b0;
         setupSecond_r <= 16'h0000;
      end else if (setupPend_r) begin
         if (fifoInReady) setupPend_r <= 1'b0;
      end else if (setupWr && fifoInReady) begin
         setupPend_r <= 1'b1;
         setupSecond_r <= setupRes;
      end
   end

   // Read answers one cycle after the request from flip-flops.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdAck_r <= 1'b0;
         avReadData <= 32'h00000000;
      end else begin
         rdAck_r <= avRead && ~rdAck_r;
         if (avRead && ~rdAck_r) begin
            avReadData <= (avAddress == `SOFC_AV_STATUS) ?
               {16'h0000, rdData_r, 5'h00, ~fifoInReady,
               ~fifoOutValid, state_r != sofc_pkg::HST_IDLE} : 32'h00000000;
         end
      end
   end

   sofc_fifo #(.WIDTH(16), .DEPTH(16)) u_cmdFifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoIn),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOut)
   );

   //////////////////////////////////////////////////////////////////
   // Read data pin through three stages.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sdoSync_r <= 3'h0;
         sdoLvl_r <= 1'b0;
      end else begin
         sdoSync_r <= {sdoSync_r[1:0], link.sdo};
         if (sdoSync_r[1] == sdoSync_r[2]) sdoLvl_r <= sdoSync_r[2];
      end
   end

   assign halfTick = (div_r == 8'(SCLK_HALF - 1));
   assign fifoOutReady = (state_r == sofc_pkg::HST_IDLE);

   // Serial master: clock divided from sys_clk, data changes on fall.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= sofc_pkg::HST_IDLE;
         div_r <= 8'h00;
         bits_r <= 5'h00;
         shift_r <= 16'h0000;
         rdData_r <= 8'h00;
         sclk_r <= 1'b0;
         csN_r <= 1'b1;
      end else begin
         div_r <= halfTick ? 8'h00 : div_r + 8'h01;
         case (state_r)
            sofc_pkg::HST_IDLE: begin
               div_r <= 8'h00;
               if (fifoOutValid) begin
                  shift_r <= fifoOut;
                  bits_r <= 5'h00;
                  csN_r <= 1'b0;
                  state_r <= sofc_pkg::HST_SHIFT;
               end
            end
            sofc_pkg::HST_SHIFT: if (halfTick) begin
               sclk_r <= ~sclk_r;
               if (~sclk_r) begin
                  bits_r <= bits_r + 5'h01;
                  if (bits_r >= `SOFC_ADDR_BITS) begin
                     rdData_r <= {rdData_r[6:0], sdoLvl_r};
                  end
               end else if (bits_r == `SOFC_FRAME_BITS) begin
                  csN_r <= 1'b1;
                  state_r <= sofc_pkg::HST_GAP;
               end else begin
                  shift_r <= {shift_r[14:0], 1'b0};
               end
            end
            sofc_pkg::HST_GAP: begin
               if (halfTick) state_r <= sofc_pkg::HST_IDLE;
            end
            default: state_r <= sofc_pkg::HST_IDLE;
         endcase
      end
   end

   assign link.sclk = sclk_r;
   assign link.csN = csN_r;
   assign link.sdi = shift_r[15];
endmodule : sofc_host
`default_nettype wire

// ### testbench/sofc_link_props.sv
// Concurrent checks on the link pins between the two ends.
`timescale 1ns/100ps
`default_nettype none
module sofc_link_props #(
   parameter int SCLK_HALF = 16
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Link pins.
   input wire logic sclk,
   input wire logic csN,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic serialData,
   input wire logic bitClock,
   input wire logic frameClock
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [1:0] live;
   logic sclkQ;
   logic inRun;
   logic [7:0] held;
   logic [4:0] rises;
   ////////////////////////////////////////////////////////////////////////////
   // Settle flag, control clock phase length and rises in each frame.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         live <= 2'h0;
         sclkQ <= 1'b0;
         inRun <= 1'b0;
         held <= 8'h00;
         rises <= 5'h00;
      end else begin
         live <= live[1] ? live : live + 2'h1;
         sclkQ <= sclk;
         held <= (sclk != sclkQ) ? 8'h00 : held + 8'h01;
         inRun <= !csN && (inRun || sclk != sclkQ);
         rises <= csN ? 5'h00 : rises + 5'(sclk && !sclkQ);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // The control clock rests low while no frame is selected.
   sclk_idle_a: assert property (csN |-> !sclk)
      else $error("control clock moved outside a frame");
   // Each control clock phase inside a frame lasts the divider count.
   sclk_half_a: assert property (
      live[1] && inRun && sclk != sclkQ |-> held == SCLK_HALF - 1)
      else $error("control clock phase has the wrong length");
   // Host data is settled when the device samples it.
   sdi_rise_a: assert property ($rose(sclk) |-> $stable(sdi))
      else $error("host data moved at a sampling edge");
   sdi_high_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
      else $error("host data moved while the clock was high");
   // A frame carries exactly sixteen sampling edges.
   frame_bits_a: assert property ($rose(csN) |-> rises == 5'h10)
      else $error("frame did not carry sixteen bits");
   // Select leads the first edge and trails the last one.
   csn_lead_a: assert property ($fell(csN) |-> !sclk [*8])
      else $error("clock rose too soon after select");
   csn_trail_a: assert property (
      $rose(csN) |-> $past(sclk) && !$past(sclk, SCLK_HALF + 1))
      else $error("select did not end a full high clock phase");
   // The serial bit clock toggles on every system clock.
   bit_clock_a: assert property (
      live[1] |-> bitClock != $past(bitClock))
      else $error("bit clock missed a toggle");
   cover property ($rose(csN));
   cover property ($rose(frameClock));
   cover property ($rose(sdo));
   cover property ($changed(serialData));
endmodule : sofc_link_props
`default_nettype wire

// ### testbench/serial_output_format_config_tb_top.sv
// Self-checking bench for both ends of the format configuration link.
`timescale 1ns/100ps
`include "sofc_regs.svh"
`default_nettype none
module serial_output_format_config_tb_top;
   localparam int HALF = 10;
   localparam logic [6:0] OFFS [6] = '{`SOFC_OFS_DRIVE, `SOFC_OFS_RESOLUTION,
      `SOFC_OFS_SKEW, `SOFC_OFS_PAT_LOW, `SOFC_OFS_PAT_MID, `SOFC_OFS_PAT_HIGH};
   // Mode, resolution register value, expected word width.
   localparam logic [14:0] RES [11] = '{{2'h0, 8'h80, 5'h12},
      {2'h0, 8'h88, 5'h10}, {2'h0, 8'h90, 5'h0e}, {2'h0, 8'h40, 5'h14},
      {2'h0, 8'h00, 5'h0e}, {2'h1, 8'h00, 5'h12}, {2'h1, 8'h08, 5'h10},
      {2'h1, 8'h10, 5'h0e}, {2'h2, 8'h00, 5'h10}, {2'h2, 8'h10, 5'h0e},
      {2'h2, 8'h40, 5'h14}};
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] avAddress = 4'h0;
   logic avRead = 1'b0;
   logic avWrite = 1'b0;
   logic [31:0] avWriteData = 32'h0;
   logic [31:0] avReadData, rd;
   logic avWaitRequest, sampleTake, halfDrive;
   sofc_pkg::sofc_decim_t decimMode = sofc_pkg::DECIM_BYPASS;
   logic [19:0] sampleIn = 20'h0, pat;
   logic decimFrame = 1'b0;
   logic [1:0] dataLaneSkew, bitClockSkew, w, dm;
   logic [2:0] res;
   logic [4:0] outBits;
   logic [31:0] qMask [$], qVal [$];
   int n_mismatch = 0;
   int cmp_count = 0;
   int stall = 0;
   int gap;
   sofc_link_if link ();
   sofc_device sofc_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(link.dev), .decimMode(decimMode), .sampleIn(sampleIn),
      .sampleTake(sampleTake), .decimFrame(decimFrame),
      .halfDrive(halfDrive), .dataLaneSkew(dataLaneSkew),
      .bitClockSkew(bitClockSkew), .outBits(outBits));
   sofc_host #(.SCLK_HALF(HALF)) sofc_host_i (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .avAddress(avAddress), .avRead(avRead),
      .avWrite(avWrite), .avWriteData(avWriteData),
      .avReadData(avReadData), .avWaitRequest(avWaitRequest),
      .link(link.host));
   sofc_link_props #(.SCLK_HALF(HALF)) sofc_link_props_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .sclk(link.sclk),
      .csN(link.csN), .sdi(link.sdi), .sdo(link.sdo),
      .serialData(link.serialData), .bitClock(link.bitClock),
      .frameClock(link.frameClock));
   ////////////////////////////////////////////////////////////////////////////
   // System clock and free-running converter samples.
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      sampleIn <= 20'($urandom);
      decimFrame <= 1'($urandom);
   end
   // Compares each noted read result as the answer arrives.
   always @(posedge sys_clk) begin
      if (avRead && !avWaitRequest && qVal.size() > 0) begin
         check(avReadData & qMask.pop_front(), qVal.pop_front());
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // One Avalon transfer, held until waitrequest is sampled low.
   task automatic bus(input logic rdNwr, input logic [3:0] a,
      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      avAddress <= a;
      avRead <= rdNwr;
      avWrite <= !rdNwr;
      avWriteData <= d;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avWaitRequest !== 1'b0 && n < 5000);
      if (n >= 5000) n_mismatch++;
      stall += n - 1;
      rd = avReadData;
      avRead <= 1'b0;
      avWrite <= 1'b0;
   endtask : bus
   // Polls status until the engine is idle and the queue empty.
   task automatic idle();
      int k;
      k = 0;
      do begin
         bus(1'b1, `SOFC_AV_STATUS, 32'h0);
         k++;
      end while (rd[1:0] !== 2'b10 && k < 2000);
      if (k >= 2000) n_mismatch++;
      repeat (8) @(posedge sys_clk);
   endtask : idle
   task automatic devWr(input logic [6:0] o, input logic [7:0] v);
      bus(1'b0, `SOFC_AV_CMD, {16'h0, 1'b0, o, v});
      idle();
   endtask : devWr
   // Reads a device register back and notes the expected byte.
   task automatic devChk(input logic [6:0] o, input logic [7:0] v);
      bus(1'b0, `SOFC_AV_CMD, {16'h0, 1'b1, o, 8'h00});
      idle();
      qMask.push_back(32'h0000ff00);
      qVal.push_back({16'h0, v, 8'h00});
      bus(1'b1, `SOFC_AV_STATUS, 32'h0);
   endtask : devChk
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the expected run length.
   initial begin
      #(5 * 90000);
      n_mismatch++;
      end_of_test();
   end
   // Main sequence of tests.
   initial begin
      void'($urandom(32'h1ddc));
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      check(32'({halfDrive, dataLaneSkew, bitClockSkew}), 32'h0);
      check(32'(outBits), 32'h0e);
      foreach (OFFS[i]) devChk(OFFS[i], 8'h00);
      qMask.push_back(32'hffffffff);
      qVal.push_back(32'h0);
      bus(1'b1, 4'hc, 32'h0);
      $display("test reset done");
      devWr(`SOFC_OFS_DRIVE, 8'h40);
      check(32'(halfDrive), 32'h1);
      devChk(`SOFC_OFS_DRIVE, 8'h40);
      devWr(`SOFC_OFS_DRIVE, 8'h00);
      check(32'(halfDrive), 32'h0);
      $display("test drive done");
      for (int i = 0; i < 16; i++) begin
         devWr(`SOFC_OFS_SKEW, 8'(i));
         check(32'(dataLaneSkew), 32'(i / 4));
         check(32'(bitClockSkew), 32'(i % 4));
      end
      $display("test skew done");
      foreach (RES[i]) begin
         decimMode <= sofc_pkg::sofc_decim_t'(RES[i][14:13]);
         devWr(`SOFC_OFS_RESOLUTION, RES[i][12:5]);
         check(32'(outBits), 32'(RES[i][4:0]));
         @(posedge sys_clk iff sampleTake);
         gap = 0;
         do begin
            @(posedge sys_clk);
            gap++;
         end while (sampleTake !== 1'b1);
         check(32'(gap), 32'(RES[i][4:0]));
      end
      $display("test resolution done");
      for (int m = 0; m < 9; m++) begin
         w = 2'(m % 3);
         dm = 2'(m / 3);
         res = 3'($urandom_range(2));
         decimMode <= sofc_pkg::sofc_decim_t'(dm);
         bus(1'b0, `SOFC_AV_SETUP, {25'h0, res, dm, w});
         idle();
         devChk(`SOFC_OFS_FRAME_CTRL, {dm == 2 && w != 2, 2'b0,
            dm != 2 && w == 0, 3'b0, dm == 2 && w == 2});
         devChk(`SOFC_OFS_RESOLUTION, {dm == 0, 1'b0, res, 3'b0});
      end
      $display("test setup done");
      stall = 0;
      for (int i = 0; i < 20; i++) begin
         pat = 20'($urandom);
         bus(1'b0, `SOFC_AV_CMD, {16'h0, 1'b0, `SOFC_OFS_PAT_LOW, pat[7:0]});
      end
      check(32'(stall > 0), 32'h1);
      idle();
      devWr(`SOFC_OFS_PAT_MID, pat[15:8]);
      devWr(`SOFC_OFS_PAT_HIGH, {4'h0, pat[19:16]});
      devChk(`SOFC_OFS_PAT_LOW, pat[7:0]);
      devChk(`SOFC_OFS_PAT_MID, pat[15:8]);
      devChk(`SOFC_OFS_PAT_HIGH, {4'h0, pat[19:16]});
      $display("test pattern done");
      @(posedge sys_clk);
      end_of_test();
   end
endmodule : serial_output_format_config_tb_top
`default_nettype wire
